// *** fmrir_pkg.sv ***
// package for the frequency meter result and interrupt register bank
// assumes a 32-bit register port with byte addresses

package fmrir_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [9:0] FMRIR_OFF_STATUS = 10'h008;
  localparam logic [9:0] FMRIR_OFF_RESULT = 10'h00C;
  localparam logic [9:0] FMRIR_OFF_IEN_SET = 10'h010;
  localparam logic [9:0] FMRIR_OFF_IEN_CLR = 10'h014;
  localparam logic [9:0] FMRIR_OFF_IEN_MASK = 10'h018;
  localparam logic [9:0] FMRIR_OFF_PEND = 10'h01C;
  localparam logic [9:0] FMRIR_OFF_PEND_CLR = 10'h020;
  localparam logic [9:0] FMRIR_OFF_REVISION = 10'h3FC;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int FMRIR_NSRC = 2;
  localparam int FMRIR_BIT_DONE = 0;
  localparam int FMRIR_BIT_REF = 1;
  localparam int FMRIR_RESULT_W = 24;
  localparam int FMRIR_VERSION_W = 12;
  localparam int FMRIR_VARIANT_LSB = 16;
  localparam int FMRIR_VARIANT_W = 4;
  localparam logic [31:0] FMRIR_ZERO_WORD = 32'h0000_0000;
  localparam logic [FMRIR_NSRC-1:0] FMRIR_IRQ_RESET = 2'h0;
  localparam logic [FMRIR_RESULT_W-1:0] FMRIR_RESULT_RESET = 24'h00_0000;
  // arbitrary value, not tied to any real part
  localparam logic [FMRIR_VERSION_W-1:0] FMRIR_VERSION_DEF = 12'h123;
  localparam logic [FMRIR_VARIANT_W-1:0] FMRIR_VARIANT_DEF = 4'h0;

  // ----------------------------------------------------------------
  // clock source selection codes
  // ----------------------------------------------------------------
  localparam int FMRIR_MSR_W = 5;
  localparam int FMRIR_REF_W = 3;
  localparam int FMRIR_NMSR = 18;
  localparam int FMRIR_NREF = 2;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_CPU = 5'h00;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_HSB = 5'h01;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_PBA = 5'h02;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_PBB = 5'h03;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_XO0 = 5'h04;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_XO32K = 5'h05;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_SYSRC = 5'h06;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_FLL = 5'h07;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_RSV8 = 5'h08;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_GEN0 = 5'h09;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_GEN5 = 5'h0E;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_FRC_DBG = 5'h0F;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_FRC_MAIN = 5'h10;
  localparam logic [FMRIR_MSR_W-1:0] FMRIR_MSR_SRC = 5'h11;
  localparam logic [FMRIR_REF_W-1:0] FMRIR_REF_SYSRC = 3'h0;
  localparam logic [FMRIR_REF_W-1:0] FMRIR_REF_XO32K = 3'h1;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } fmrir_req_t;

  typedef struct packed {
    logic ref_busy;
    logic meas_busy;
  } fmrir_status_t;

  typedef enum logic [1:0] {
    FMRIR_FLAG_IDLE = 2'b00,
    FMRIR_FLAG_HIGH = 2'b01
  } fmrir_edge_t;

endpackage : fmrir_pkg

// *** fmrir_sync.sv ***
// two-stage synchroniser with falling-edge pulse
// assumes input comes from an unrelated clock domain
`timescale 1ns/100ps

module fmrir_sync
  import fmrir_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic async_in,
  output logic level_out,
  output logic fall_pulse
);

  logic meta_q;
  logic sync_q;
  fmrir_edge_t st_q;
  fmrir_edge_t st_d;

  // ----------------------------------------------------------------
  // edge tracker, only looks at the second stage
  // ----------------------------------------------------------------
  always_comb begin
    case (st_q)
      FMRIR_FLAG_IDLE: st_d = sync_q ? FMRIR_FLAG_HIGH : FMRIR_FLAG_IDLE;
      FMRIR_FLAG_HIGH: st_d = sync_q ? FMRIR_FLAG_HIGH : FMRIR_FLAG_IDLE;
      default: st_d = FMRIR_FLAG_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      st_q <= FMRIR_FLAG_IDLE;
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
      st_q <= st_d;
    end
  end

  assign level_out = sync_q;
  // [RULE5] one to zero
  assign fall_pulse = ce && (st_q == FMRIR_FLAG_HIGH) && !sync_q;

endmodule : fmrir_sync

// *** fmrir_srcsel.sv ***
// clock source decode for measured and reference selectors
// assumes select codes come from the mode register outside
`timescale 1ns/100ps

module fmrir_srcsel
  import fmrir_pkg::*;
(
  input wire logic [FMRIR_MSR_W-1:0] measured_source_select,
  input wire logic [FMRIR_REF_W-1:0] reference_source_select,
  output logic [FMRIR_NMSR-1:0] msr_onehot,
  output logic [FMRIR_NREF-1:0] ref_onehot
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // [RULE11] [RULE12] measured codes
  genvar gi;
  generate
    for (gi = 0; gi < FMRIR_NMSR; gi++) begin : g_msr
      if (gi == int'(FMRIR_MSR_RSV8)) begin : g_rsv
        // [RULE15] reserved code routes nothing
        assign msr_onehot[gi] = 1'b0;
      end else begin : g_sel
        assign msr_onehot[gi] =
          (measured_source_select == FMRIR_MSR_W'(gi));
      end
    end
  endgenerate

  // [RULE13] [RULE15] reference codes
  assign ref_onehot[0] = (reference_source_select == FMRIR_REF_SYSRC);
  assign ref_onehot[1] = (reference_source_select == FMRIR_REF_XO32K);

endmodule : fmrir_srcsel

// *** fmrir_regs.sv ***
// frequency meter result and interrupt register bank
// assumes busy flags arrive from other clock domains; bus is on mclk
//
// Contract
// [RULE1] result register shows last completed count
// [RULE2] enable-set ones set mask bits
// [RULE3] enable-clear ones clear mask bits
// [RULE4] mask register reads enables, resets zero
// [RULE5] pending set on busy falling edge
// [RULE6] pending-clear ones clear pending flags
// [RULE7] irq is OR of masked pending
// [RULE8] status: busy bit0, ref busy bit1
// [RULE9] revision holds 12-bit version
// [RULE10] variant field reserved, no function
// [RULE11] measured codes 0-7 route listed clocks
// [RULE12] codes 9-17 generic, fast, slow rc
// [RULE13] reference codes 0 and 1 only
// [RULE14] 24-bit result, upper bits zero
// [RULE15] reserved codes connect no source
// [RULE16] busy edges synchronised before use
`timescale 1ns/100ps

module fmrir_regs
  import fmrir_pkg::*;
#(
  parameter logic [FMRIR_VERSION_W-1:0] VERSION_ID = FMRIR_VERSION_DEF,
  parameter logic [FMRIR_VARIANT_W-1:0] VARIANT_ID = FMRIR_VARIANT_DEF
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic meas_busy,
  input wire logic reference_clock_pending,
  input wire logic [FMRIR_RESULT_W-1:0] meas_count,
  input wire logic [FMRIR_MSR_W-1:0] measured_source_select,
  input wire logic [FMRIR_REF_W-1:0] reference_source_select,
  output logic [FMRIR_NMSR-1:0] msr_onehot,
  output logic [FMRIR_NREF-1:0] ref_onehot,
  output logic irq
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [9:0] a, input logic [9:0] o);
    hit = (a == o);
  endfunction : hit

  fmrir_req_t req;
  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  wire wr_set = ce && req.wr && hit(req.addr, FMRIR_OFF_IEN_SET);
  wire wr_clr = ce && req.wr && hit(req.addr, FMRIR_OFF_IEN_CLR);
  wire wr_pclr = ce && req.wr && hit(req.addr, FMRIR_OFF_PEND_CLR);
  wire [FMRIR_NSRC-1:0] wbits = req.wdata[FMRIR_NSRC-1:0];

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  fmrir_status_t status;
  logic [FMRIR_NSRC-1:0] fall;

  // [RULE16] sync busy
  fmrir_sync u_sync_busy (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .async_in(meas_busy),
    .level_out(status.meas_busy),
    .fall_pulse(fall[FMRIR_BIT_DONE])
  );

  // [RULE16] sync ref busy
  fmrir_sync u_sync_ref (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .async_in(reference_clock_pending),
    .level_out(status.ref_busy),
    .fall_pulse(fall[FMRIR_BIT_REF])
  );

  fmrir_srcsel u_srcsel (
    .measured_source_select(measured_source_select),
    .reference_source_select(reference_source_select),
    .msr_onehot(msr_onehot),
    .ref_onehot(ref_onehot)
  );

  // ----------------------------------------------------------------
  // mask, pending, result
  // ----------------------------------------------------------------
  logic [FMRIR_NSRC-1:0] mask_q;
  logic [FMRIR_NSRC-1:0] mask_d;
  logic [FMRIR_NSRC-1:0] pend_q;
  logic [FMRIR_NSRC-1:0] pend_d;
  logic [FMRIR_RESULT_W-1:0] result_q;
  logic [FMRIR_RESULT_W-1:0] result_d;

  // [RULE2] [RULE3] set then clear; a same-cycle clear wins for mask
  assign mask_d = (mask_q | (wr_set ? wbits : FMRIR_IRQ_RESET))
    & ~(wr_clr ? wbits : FMRIR_IRQ_RESET);
  // [RULE5] [RULE6] an edge beats a clear in the same cycle
  assign pend_d = (pend_q & ~(wr_pclr ? wbits : FMRIR_IRQ_RESET)) | fall;
  // [RULE1] capture at done edge; count is stable when busy falls
  assign result_d = fall[FMRIR_BIT_DONE] ? meas_count : result_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= FMRIR_IRQ_RESET;
      pend_q <= FMRIR_IRQ_RESET;
      result_q <= FMRIR_RESULT_RESET;
    end else if (ce) begin
      mask_q <= mask_d;
      pend_q <= pend_d;
      result_q <= result_d;
    end
  end

  // [RULE7] masked or
  assign irq = |(pend_q & mask_q);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rmux;
  logic [31:0] rdata_q;

  always_comb begin
    rmux = FMRIR_ZERO_WORD;
    case (req.addr)
      // [RULE8] status bits
      FMRIR_OFF_STATUS: rmux[FMRIR_NSRC-1:0] = status;
      // [RULE14] upper zero
      FMRIR_OFF_RESULT: rmux[FMRIR_RESULT_W-1:0] = result_q;
      // [RULE4] mask view
      FMRIR_OFF_IEN_MASK: rmux[FMRIR_NSRC-1:0] = mask_q;
      FMRIR_OFF_PEND: rmux[FMRIR_NSRC-1:0] = pend_q;
      // [RULE9] [RULE10] version and variant
      FMRIR_OFF_REVISION: begin
        rmux[FMRIR_VERSION_W-1:0] = VERSION_ID;
        rmux[FMRIR_VARIANT_LSB +: FMRIR_VARIANT_W] = VARIANT_ID;
      end
      default: rmux = FMRIR_ZERO_WORD;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= FMRIR_ZERO_WORD;
    end else if (ce) begin
      rdata_q <= req.rd ? rmux : FMRIR_ZERO_WORD;
    end
  end

  assign rdata = rdata_q;

endmodule : fmrir_regs

// *** fmrir_regs_monitor.sv ***
// checker on the register bank ports
// assumes it is bound to fmrir_regs, with the bus on mclk
`timescale 1ns/100ps

module fmrir_regs_monitor
  import fmrir_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [9:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic meas_busy,
  input wire logic reference_clock_pending,
  input wire logic [FMRIR_MSR_W-1:0] measured_source_select,
  input wire logic [FMRIR_REF_W-1:0] reference_source_select,
  input wire logic [FMRIR_NMSR-1:0] msr_onehot,
  input wire logic [FMRIR_NREF-1:0] ref_onehot,
  input wire logic irq
);
  // ----------------------------------------------------------------
  // recent busy falls
  // ----------------------------------------------------------------
  logic [1:0] busy_q;
  logic [4:0] fall_q;
  wire [1:0] busy_now = {reference_clock_pending, meas_busy};

  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // a window, not an exact count, so the sync depth stays the designer's
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= 2'h0;
      fall_q <= 5'h00;
    end else begin
      busy_q <= busy_now;
      fall_q <= {fall_q[3:0], |(busy_q & ~busy_now)};
    end
  end

  property p_rdata_idle;
    !$past(rd) |-> rdata == FMRIR_ZERO_WORD;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside an answer");

  property p_result_top;
    $past(rd) && $past(addr) == FMRIR_OFF_RESULT |-> rdata[31:24] == 8'h00;
  endproperty
  a_result_top: assert property (p_result_top)
    else $error("result upper byte not zero");

  property p_rev_rsvd;
    $past(rd) && $past(addr) == FMRIR_OFF_REVISION
      |-> rdata[31:20] == 12'h000 && rdata[15:12] == 4'h0;
  endproperty
  a_rev_rsvd: assert property (p_rev_rsvd)
    else $error("revision unused bits not zero");

  property p_mask_top;
    $past(rd) && $past(addr) == FMRIR_OFF_IEN_MASK |-> rdata[31:2] == 30'h0;
  endproperty
  a_mask_top: assert property (p_mask_top)
    else $error("mask upper bits not zero");

  property p_irq_fall;
    $fell(irq) |-> $past(wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without a register write");

  property p_irq_rise;
    $rose(irq) |-> $past(wr) || (|fall_q);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("irq rose without write or busy fall");

  property p_msr_dec;
    msr_onehot == ((measured_source_select < 5'h12 &&
      measured_source_select != FMRIR_MSR_RSV8) ?
      18'h00001 << measured_source_select : 18'h00000);
  endproperty
  a_msr_dec: assert property (p_msr_dec)
    else $error("measured source decode wrong");

  property p_ref_dec;
    ref_onehot == (reference_source_select < 3'h2 ?
      2'h1 << reference_source_select : 2'h0);
  endproperty
  a_ref_dec: assert property (p_ref_dec)
    else $error("reference source decode wrong");
endmodule : fmrir_regs_monitor

bind fmrir_regs fmrir_regs_monitor fmrir_regs_monitor_i (.mclk, .rstn,
  .addr, .wr, .rd, .rdata, .meas_busy, .reference_clock_pending,
  .measured_source_select, .reference_source_select, .msr_onehot,
  .ref_onehot, .irq);

// *** fmrir_regs_tb.sv ***
// self-checking bench for the register bank
// clock enable held high except for one set write; busy inputs driven on mclk
`timescale 1ns/100ps

module fmrir_regs_tb;
  import fmrir_pkg::*;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end

  logic mclk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, irq;
  logic meas_busy = 1'b0, reference_clock_pending = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [FMRIR_RESULT_W-1:0] meas_count = 24'h0, res_m = 24'h0;
  logic [FMRIR_MSR_W-1:0] measured_source_select = 5'h00;
  logic [FMRIR_REF_W-1:0] reference_source_select = 3'h0;
  logic [FMRIR_NMSR-1:0] msr_onehot;
  logic [FMRIR_NREF-1:0] ref_onehot, mask_m = 2'h0, pend_m = 2'h0;
  int failures = 0, samples_checked = 0, seed = 40;

  fmrir_regs fmrir_regs_i (.mclk, .rstn, .ce, .addr, .wdata, .wr, .rd,
    .rdata, .meas_busy, .reference_clock_pending, .meas_count,
    .measured_source_select, .reference_source_select, .msr_onehot,
    .ref_onehot, .irq);

  initial begin
    forever #50 mclk = ~mclk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic wr_reg(input logic [9:0] a, input logic [31:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input string n, input logic [9:0] a,
      input logic [31:0] e);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    `CHK(n, e, rdata)
  endtask : rd_chk

  task automatic chk_all();
    rd_chk("mask", FMRIR_OFF_IEN_MASK, {30'h0, mask_m});
    rd_chk("pending", FMRIR_OFF_PEND, {30'h0, pend_m});
    rd_chk("result", FMRIR_OFF_RESULT, {8'h00, res_m});
    `CHK("irq", |(mask_m & pend_m), irq)
  endtask : chk_all

  // busy held 4+ cycles so the synchroniser always sees it
  task automatic busy_pulse(input logic w, input logic [23:0] c);
    @(posedge mclk);
    if (w) reference_clock_pending <= 1'b1;
    else meas_busy <= 1'b1;
    meas_count <= c;
    repeat (3) @(posedge mclk);
    rd_chk("status", FMRIR_OFF_STATUS, {30'h0, w, !w});
    @(posedge mclk);
    meas_busy <= 1'b0;
    reference_clock_pending <= 1'b0;
    rd_chk("early", FMRIR_OFF_PEND, {30'h0, pend_m});
    repeat (2) @(posedge mclk);
    pend_m[w] = 1'b1;
    if (!w) res_m = c;
  endtask : busy_pulse

  function automatic logic [17:0] exp_msr(input int c);
    return (c < 18 && c != 8) ? 18'h00001 << c : 18'h00000;
  endfunction : exp_msr

  initial begin
    #5000000;
    failures++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    chk_all();
    rd_chk("status", FMRIR_OFF_STATUS, FMRIR_ZERO_WORD);
    rd_chk("revision", FMRIR_OFF_REVISION,
      {12'h000, FMRIR_VARIANT_DEF, 4'h0, FMRIR_VERSION_DEF});
    rd_chk("wo_set", FMRIR_OFF_IEN_SET, FMRIR_ZERO_WORD);
    rd_chk("unmapped", 10'h100, FMRIR_ZERO_WORD);
    wr_reg(FMRIR_OFF_RESULT, 32'hFFFF_FFFF);
    wr_reg(FMRIR_OFF_IEN_MASK, 32'hFFFF_FFFF);
    // clock enable low: a set write must not land
    @(posedge mclk);
    ce <= 1'b0;
    wr_reg(FMRIR_OFF_IEN_SET, 32'h0000_0003);
    ce <= 1'b1;
    chk_all();
    for (int i = 0; i < 60; i++) begin
      d = $random(seed);
      if (d[31:30] == 2'h3) begin
        busy_pulse(d[29], d[23:0]);
      end else begin
        wr_reg(d[31] ? FMRIR_OFF_PEND_CLR : d[30] ? FMRIR_OFF_IEN_CLR :
          FMRIR_OFF_IEN_SET, d);
        if (d[31]) pend_m &= ~d[1:0];
        else if (d[30]) mask_m &= ~d[1:0];
        else mask_m |= d[1:0];
      end
      chk_all();
    end
    for (int c = 0; c < 32; c++) begin
      @(posedge mclk);
      measured_source_select <= c[4:0];
      reference_source_select <= c[2:0];
      @(posedge mclk);
      #1;
      `CHK("msr_sel", exp_msr(c), msr_onehot)
      `CHK("ref_sel", c[2:1] == 2'h0 ? 2'h1 << c[0] : 2'h0, ref_onehot)
    end
    end_of_test();
  end
endmodule : fmrir_regs_tb
